// ==== pkg/asrc_pkg.sv ====
package asrc_pkg;

  localparam int ADDR_W        = 19;
  localparam int DATA_W        = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CNT_W         = 8;

  // Timing figures in ns, fast grade then slow grade
  localparam int T_RC_FAST_NS  = 70;
  localparam int T_RC_SLOW_NS  = 85;
  localparam int T_AA_FAST_NS  = 70;
  localparam int T_AA_SLOW_NS  = 85;
  localparam int T_OE_FAST_NS  = 35;
  localparam int T_OE_SLOW_NS  = 45;
  localparam int T_HZ_FAST_NS  = 30;
  localparam int T_HZ_SLOW_NS  = 35;
  localparam int T_WC_FAST_NS  = 70;
  localparam int T_WC_SLOW_NS  = 85;
  localparam int T_CW_FAST_NS  = 60;
  localparam int T_CW_SLOW_NS  = 75;
  localparam int T_WP_FAST_NS  = 50;
  localparam int T_WP_SLOW_NS  = 55;
  localparam int T_DW_FAST_NS  = 30;
  localparam int T_DW_SLOW_NS  = 35;
  localparam int T_WHZ_FAST_NS = 30;
  localparam int T_WHZ_SLOW_NS = 35;

  function automatic int cyc_up(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  // Access wait covers both address access and output enable access
  localparam int RD_CYC_FAST = cyc_up(max3(T_RC_FAST_NS, T_AA_FAST_NS, T_OE_FAST_NS));
  localparam int RD_CYC_SLOW = cyc_up(max3(T_RC_SLOW_NS, T_AA_SLOW_NS, T_OE_SLOW_NS));
  localparam int HZ_CYC_FAST = cyc_up(max3(T_HZ_FAST_NS, T_WHZ_FAST_NS, 0));
  localparam int HZ_CYC_SLOW = cyc_up(max3(T_HZ_SLOW_NS, T_WHZ_SLOW_NS, 0));
  localparam int WP_CYC_FAST = cyc_up(max3(T_WP_FAST_NS, T_CW_FAST_NS, T_DW_FAST_NS + T_WHZ_FAST_NS));
  localparam int WP_CYC_SLOW = cyc_up(max3(T_WP_SLOW_NS, T_CW_SLOW_NS, T_DW_SLOW_NS + T_WHZ_SLOW_NS));
  localparam int WC_CYC_FAST = cyc_up(T_WC_FAST_NS);
  localparam int WC_CYC_SLOW = cyc_up(T_WC_SLOW_NS);
  localparam int RC_CYC_FAST = cyc_up(T_RC_FAST_NS);
  localparam int RC_CYC_SLOW = cyc_up(T_RC_SLOW_NS);

  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic              cs_n;
    logic              we_n;
    logic              oe_n;
    logic [DATA_W-1:0] shared_data_bus_o;
    logic              shared_data_bus_oe;
  } asrc_pins_t;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_READ    = 7'h02,
    ST_RD_HZ   = 7'h04,
    ST_WRITE   = 7'h08,
    ST_WR_TAIL = 7'h10,
    ST_RETAIN  = 7'h20,
    ST_RESUME  = 7'h40
  } asrc_state_t;

endpackage

// ==== verilog/asrc_host.sv ====
`timescale 1ns/1ns
// Summary of operation
// RULE_01 - 512K bytes, 19-bit address, byte access
// RULE_02 - Device is static, no refresh needed
// RULE_03 - One shared three-state byte bus
// RULE_04 - Deselected device ignores inputs, floats bus
// RULE_05 - Read data valid 70/85 ns after address
// RULE_06 - Output enable access 35/45 ns
// RULE_07 - Old data held 10 ns after address
// RULE_08 - Bus floats within 30/35 ns
// RULE_09 - Each cycle lasts at least 70/85 ns
// RULE_10 - Write spans overlap of select and strobe
// RULE_11 - Write window at least 50/55 ns
// RULE_12 - Select low 60/75 ns before write end
// RULE_13 - Address stable from write start to end
// RULE_14 - Output-drive-low write widened against contention
// RULE_15 - Never drive bus while device drives
// RULE_16 - Select with strobe keeps outputs floating
// RULE_17 - Output-drive-low write echoes then reads next
// RULE_18 - Deselect before retention, recover one read cycle
// RULE_19 - Retained contents survive floating inputs
// RULE_20 - Read drives byte only with output drive low
// RULE_21 - Select and strobe low always write
module asrc_host #(
  parameter bit FAST_GRADE = 1'b1
) (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire logic                      req_valid,
  input  wire asrc_pkg::asrc_req_t       req,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output logic [asrc_pkg::DATA_W-1:0]    rsp_rdata,
  input  wire logic                      retain_req,
  output logic                           retain_active,
  output asrc_pkg::asrc_pins_t           pins,
  input  wire logic [asrc_pkg::DATA_W-1:0] shared_data_bus_i
);
  import asrc_pkg::*;

  localparam int RD_CYC_I = FAST_GRADE ? RD_CYC_FAST : RD_CYC_SLOW;
  localparam int HZ_CYC_I = FAST_GRADE ? HZ_CYC_FAST : HZ_CYC_SLOW;
  localparam int WP_CYC_I = FAST_GRADE ? WP_CYC_FAST : WP_CYC_SLOW;
  localparam int WC_CYC_I = FAST_GRADE ? WC_CYC_FAST : WC_CYC_SLOW;
  localparam int RC_CYC_I = FAST_GRADE ? RC_CYC_FAST : RC_CYC_SLOW;
  localparam int TAIL_I   = (WC_CYC_I > WP_CYC_I) ? (WC_CYC_I - WP_CYC_I) : 1;

  localparam logic [CNT_W-1:0] RD_LOAD   = CNT_W'(RD_CYC_I - 1);
  localparam logic [CNT_W-1:0] HZ_LOAD   = CNT_W'(HZ_CYC_I - 1);
  localparam logic [CNT_W-1:0] WP_LOAD   = CNT_W'(WP_CYC_I - 1);
  localparam logic [CNT_W-1:0] TAIL_LOAD = CNT_W'(TAIL_I - 1);
  localparam logic [CNT_W-1:0] RC_LOAD   = CNT_W'(RC_CYC_I - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;

  asrc_state_t       state;
  asrc_state_t       next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic              accept;
  logic              cnt_done;
  logic              cs_n;
  logic              we_n;
  logic              oe_n;
  logic [ADDR_W-1:0] word_address;
  logic [DATA_W-1:0] wdata_out;
  logic              bus_drive;

  assign accept   = req_valid && req_ready && !retain_req;
  assign cnt_done = (cnt == CNT_ZERO);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (!cnt_done) begin
      next_cnt = cnt - 8'h01;
    end
    case (state)
      ST_IDLE: begin
        if (retain_req) begin
          // Select is already high in idle
          next_state = ST_RETAIN; // see RULE_18
        end else if (accept) begin
          if (req.write) begin
            next_state = ST_WRITE; // see RULE_21
            next_cnt   = WP_LOAD; // see RULE_11
          end else begin
            next_state = ST_READ; // see RULE_20
            next_cnt   = RD_LOAD; // see RULE_05
          end
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          next_state = ST_RD_HZ;
          next_cnt   = HZ_LOAD; // see RULE_08
        end
      end
      ST_RD_HZ: begin
        if (cnt_done) begin
          next_state = ST_IDLE; // see RULE_15
        end
      end
      ST_WRITE: begin
        if (cnt_done) begin
          next_state = ST_WR_TAIL;
          next_cnt   = TAIL_LOAD; // see RULE_09
        end
      end
      ST_WR_TAIL: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        if (!retain_req) begin
          next_state = ST_RESUME;
          next_cnt   = RC_LOAD; // see RULE_18
        end
      end
      ST_RESUME: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt   <= CNT_ZERO;
    end else if (ce) begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Ready only while idle, so a request is never taken mid-cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      req_ready <= 1'b0;
    end else if (ce) begin
      req_ready <= (next_state == ST_IDLE);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      retain_active <= 1'b0;
    end else if (ce) begin
      retain_active <= (next_state == ST_RETAIN); // see RULE_18
    end
  end

  // Select and write strobe fall and rise on the same edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_n <= 1'b1;
      we_n <= 1'b1;
    end else if (ce) begin
      cs_n <= !((next_state == ST_READ) || (next_state == ST_WRITE)); // see RULE_10
      we_n <= !(next_state == ST_WRITE); // see RULE_12
    end
  end

  // Output drive stays high for writes so the bus is never contended
  always_ff @(posedge mclk) begin
    if (srst) begin
      oe_n <= 1'b1;
    end else if (ce) begin
      oe_n <= !(next_state == ST_READ); // see RULE_14
    end
  end

  // Address and write data latched at accept, held to end of cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      word_address <= ADDR_RST;
      wdata_out    <= DATA_RST;
    end else if (ce && state == ST_IDLE && accept) begin
      word_address <= req.addr; // see RULE_13
      wdata_out    <= req.wdata; // see RULE_01
    end
  end

  // Data driven only inside the write strobe, after the read float wait
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_drive <= 1'b0;
    end else if (ce) begin
      bus_drive <= (next_state == ST_WRITE); // see RULE_15
    end
  end

  // Pin bundle gathered from the individual flops
  assign pins = {
    word_address,
    cs_n,
    we_n,
    oe_n,
    wdata_out,
    bus_drive
  };

  // Read data taken once the full access time has elapsed
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= DATA_RST;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      if (state == ST_READ && cnt_done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= shared_data_bus_i; // see RULE_06
      end
    end
  end

endmodule

// ==== test/asrc_checker.sv ====
`timescale 1ns/1ns
module asrc_checker (
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire asrc_pkg::asrc_pins_t pins,
  input wire logic                 retain_active
);
  import asrc_pkg::*;
  int wl;
  int cl;
  int gap;
  always_ff @(posedge mclk) begin
    wl <= pins.we_n ? 0 : wl + 1;
  end
  always_ff @(posedge mclk) begin
    cl <= pins.cs_n ? 0 : cl + 1;
  end
  // Cycles since the last select fall
  always_ff @(posedge mclk) begin
    if (srst) gap <= 255;
    else if ($fell(pins.cs_n)) gap <= 0;
    else if (gap < 255) gap <= gap + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence hi8; pins.cs_n [*8]; endsequence
  sequence addr_kept; $stable(pins.word_address) [*3]; endsequence
  wr_width_a: assert property ($rose(pins.we_n) |-> wl >= 15)
    else $error("write pulse short");
  cs_width_a: assert property ($rose(pins.cs_n) && !$past(pins.we_n) |-> cl >= 15)
    else $error("select low too short");
  addr_hold_a: assert property (!pins.we_n && !$past(pins.we_n) |-> $stable(pins.word_address))
    else $error("address moved in write");
  addr_tail_a: assert property ($rose(pins.we_n) |-> addr_kept)
    else $error("address moved in tail");
  oe_off_a: assert property (!pins.we_n |-> pins.oe_n)
    else $error("output drive low in write");
  no_contend_a: assert property (pins.shared_data_bus_oe |-> pins.oe_n)
    else $error("bus contention");
  write_drive_a: assert property (!pins.we_n |-> pins.shared_data_bus_oe)
    else $error("write strobe without data");
  float_wait_a: assert property ($rose(pins.oe_n) |-> !pins.shared_data_bus_oe [*8])
    else $error("drive before float");
  cyc_len_a: assert property ($fell(pins.cs_n) |-> gap >= 17)
    else $error("cycle too short");
  ret_cs_a: assert property (retain_active |-> pins.cs_n)
    else $error("select low in retention");
  ret_rec_a: assert property ($fell(retain_active) |-> hi8 ##1 hi8 ##1 pins.cs_n [*2])
    else $error("recovery too short");
endmodule

// ==== test/asrc_sram_model.sv ====
`timescale 1ns/1ns
module asrc_sram_model #(
  parameter int T_ACC = asrc_pkg::T_AA_FAST_NS,
  parameter int T_OFF = asrc_pkg::T_HZ_FAST_NS
) (
  input  wire asrc_pkg::asrc_pins_t  pins,
  output logic [asrc_pkg::DATA_W-1:0] bus
);
  import asrc_pkg::*;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] q = 8'h00;
  logic [DATA_W-1:0] last = 8'h00;
  logic              rdv = 1'b0;
  wire wr = !pins.cs_n && !pins.we_n;
  wire rd = !pins.cs_n && pins.we_n && !pins.oe_n;
  always @(negedge wr) mem[pins.word_address] = pins.shared_data_bus_o;
  // Old byte stays until the access time runs out
  always @(pins.word_address or rd) q <= #T_ACC (mem.exists(pins.word_address) ? mem[pins.word_address] : DATA_RST);
  always @(posedge rd) rdv <= #T_ACC 1'b1;
  // Outputs keep driving up to the float time after the read ends
  always @(negedge rd) rdv <= #T_OFF 1'b0;
  // Floating bus shows the inverse of its last level
  assign bus = pins.shared_data_bus_oe ? pins.shared_data_bus_o : rdv ? q : ~last;
  always @(bus) if (pins.shared_data_bus_oe || rdv) last = bus;
endmodule

// ==== test/asrc_host_tb.sv ====
`timescale 1ns/1ns
module asrc_host_tb;
  import asrc_pkg::*;
  logic              mclk = 0;
  logic              srst = 1;
  logic              req_valid = 0;
  logic              retain_req = 0;
  asrc_req_t         req = '0;
  logic              req_ready;
  logic              rsp_valid;
  logic              retain_active;
  logic [DATA_W-1:0] rsp_rdata;
  logic [DATA_W-1:0] bus;
  asrc_pins_t        pins;
  int                bad_count = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                seed = 32'hae5b;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  asrc_host #(.FAST_GRADE(1'b1)) dut (.mclk(mclk), .srst(srst), .ce(1'b1), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_req(retain_req),
    .retain_active(retain_active), .pins(pins), .shared_data_bus_i(bus));
  asrc_sram_model mem_i (.pins(pins), .bus(bus));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 5000) begin
    bad_count++;
    stop_test();
  end
  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      $display("Error at %0t: got %h expected %h", $time, got, want);
      bad_count++;
    end
  endtask
  function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : DATA_RST;
  endfunction
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req_valid = 1;
    req = '{w, a, d};
    while (req_ready !== 1'b1) @(posedge mclk) #1;
    @(posedge mclk) #1;
    req_valid = 0;
    if (w) begin
      ref_mem[a] = d;
      @(posedge mclk) #1;
    end else begin
      while (rsp_valid !== 1'b1) @(posedge mclk) #1;
      chk(rsp_rdata, exp_rd(a));
    end
  endtask
  initial begin
    logic [ADDR_W-1:0] a;
    repeat (16) @(posedge mclk);
    #1 srst = 0;
    for (int i = 0; i < 24; i++) begin
      a = (i < 2) ? {ADDR_W{i[0]}} : ADDR_W'($random(seed));
      xfer(1, a, 8'($random(seed)));
      xfer(1, a ^ 19'h1, 8'($random(seed)));
      xfer(0, a, 8'h00);
      xfer(0, a ^ 19'h1, 8'h00);
    end
    retain_req = 1;
    repeat (12) @(posedge mclk) #1;
    chk(retain_active, 1);
    chk(pins.cs_n, 1);
    chk(req_ready, 0);
    retain_req = 0;
    xfer(0, a, 8'h00);
    stop_test();
  end
endmodule
bind asrc_host asrc_checker chk_i (.mclk(mclk), .srst(srst), .pins(pins), .retain_active(retain_active));
